/* tb/osc_capture_asserts.sv */
// Port checks for the oscillator period capture timer
`timescale 1ns/100ps
module cap_chk
(
   input wire logic                     i_ref_clk,
   input wire logic                     i_srst,
   input wire osc_capture_pkg::ctrl_t   i_ctrl,
   input wire logic                     i_rtc_osc,
   input wire logic                     i_ext_osc,
   input wire logic                     i_comparator,
   input wire logic                     i_flag_clear,
   input wire logic                     i_irq_enable,
   input wire osc_capture_pkg::status_t o_status,
   input wire logic [7:0]               o_counter_high_byte,
   input wire logic [7:0]               o_counter_low_byte,
   input wire logic                     o_capture,
   input wire logic                     o_irq
);
   // Count and captured pair as whole words
   wire logic [15:0] cnt = {o_counter_high_byte, o_counter_low_byte};
   wire logic [15:0] rld = {o_status.reload_high_byte,
                            o_status.reload_low_byte};
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (i_srst);
   ////////////////////////////////////////////////////////////////////////////
   property p_off; !i_ctrl.osc_capture_enable |-> !o_capture; endproperty
   a_off: assert property (p_off) else $error("stray capture");
   property p_rtc; i_ctrl.osc_capture_enable && !i_ctrl.capture_source_select
      && $rose(i_rtc_osc) |-> o_capture; endproperty
   a_rtc: assert property (p_rtc) else $error("missed capture");
   property p_load; o_capture |=> rld == $past(cnt); endproperty
   a_load: assert property (p_load) else $error("bad reload");
   property p_flag; o_capture |=> o_status.high_overflow_flag; endproperty
   a_flag: assert property (p_flag) else $error("flag not set");
   property p_irq; o_irq == (o_status.high_overflow_flag && i_irq_enable);
   endproperty
   a_irq: assert property (p_irq) else $error("bad irq");
   // Capture must not disturb the count, so every running system clock cycle adds exactly one
   property p_step; i_ctrl.run && (i_ctrl.low_byte_system_clock_select ||
      &i_ctrl.clock_select) |=> cnt == $past(cnt) + 16'h0001; endproperty
   a_step: assert property (p_step) else $error("bad step");
   // Stable control only: a fresh select may tick on the old phase
   property p_div; i_ctrl.run && i_ctrl.clock_select == 2'h0 &&
      !i_ctrl.low_byte_system_clock_select && $stable(i_ctrl) && $changed(cnt)
      |=> (i_ctrl.clock_select != 2'h0 || $stable(cnt)) [*8]; endproperty
   a_div: assert property (p_div) else $error("fast prescale");
endmodule
bind osc_period_capture cap_chk chk_u (.*);

/* tb/osc_period_capture_test.sv */
// Self-checking bench for the oscillator period capture timer
`timescale 1ns/100ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin error_cnt++; \
   $display("mismatch at %0t got %h exp %h", $time, a, b); end end
module osc_period_capture_test;
   logic                     clk = 1'b0;
   logic                     srst = 1'b1;
   osc_capture_pkg::ctrl_t   ctrl = 7'h00;
   logic                     cmp = 1'b0;
   logic                     clr = 1'b0;
   logic                     irq_en = 1'b1;
   logic                     rtc, ext, cap, irq;
   logic [7:0]               hi, lo;
   osc_capture_pkg::status_t st;
   logic [15:0]              a, b;
   int                       error_cnt = 0;
   int                       cmp_count = 0;
   int                       cyc = 0;
   // Design with an oscillator model on each capture input
   osc_period_capture dut_u (.i_ref_clk(clk), .i_srst(srst), .i_ctrl(ctrl),
      .i_rtc_osc(rtc), .i_ext_osc(ext), .i_comparator(cmp),
      .i_flag_clear(clr), .i_irq_enable(irq_en), .o_status(st),
      .o_counter_high_byte(hi), .o_counter_low_byte(lo), .o_capture(cap),
      .o_irq(irq));
   slow_osc rtc_u (.i_ref_clk(clk), .i_half(8'h14), .o_osc(rtc));
   slow_osc ext_u (.i_ref_clk(clk), .i_half(8'h02), .o_osc(ext));
   initial
      forever #20 clk = ~clk;
   // Comparator toggles each cycle; hang limit well past the run length
   always @(posedge clk)
   begin
      cmp <= #1 ~cmp;
      cyc++;
      if (cyc == 5000)
      begin
         error_cnt++;
         end_sim();
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // Pulse is combinational, so look mid-cycle; reload lands one edge on
   task automatic grab(output logic [15:0] v);
      int k;
      k = 0;
      @(negedge clk);
      while (cap !== 1'b1 && k < 600)
      begin
         @(negedge clk);
         k++;
      end
      `CHK(cap, 1'b1)
      @(negedge clk);
      v = {st.reload_high_byte, st.reload_low_byte};
   endtask
   task automatic t_rtc;
      ctrl = 7'h49;
      grab(a);
      grab(b);
      `CHK(b - a, 16'h0028)
      `CHK({st.high_overflow_flag, irq}, 2'h3)
      tick(1);
      clr = 1'b1;
      tick(1);
      clr = 1'b0;
      `CHK(st.high_overflow_flag, 1'b0)
      $display("rtc capture test done");
   endtask
   task automatic t_ext;
      ctrl = 7'h5f;
      grab(a);
      grab(b);
      `CHK(b - a, 16'h0020)
      tick(1);
      irq_en = 1'b0;
      #1 `CHK({st.high_overflow_flag, irq}, 2'h2)
      tick(1);
      irq_en = 1'b1;
      $display("ext capture test done");
   endtask
   // Each counting source over a window that is a whole number of ticks
   task automatic t_sel;
      int wins [4] = '{120, 320, 40, 50};
      int adds [4] = '{10, 10, 20, 50};
      for (int s = 0; s < 4; s++)
      begin
         ctrl = {4'h0, 2'(s), 1'b1};
         tick(2);
         a = {hi, lo};
         tick(wins[s]);
         `CHK({hi, lo} - a, 16'(adds[s]))
      end
      $display("count source test done");
   endtask
   initial
   begin
      tick(6);
      srst = 1'b0;
      `CHK({hi, lo, st}, 33'h0)
      t_rtc();
      t_ext();
      t_sel();
      end_sim();
   end
endmodule

/* tb/slow_osc.sv */
// Slow oscillator model driving one capture or counting input
`timescale 1ns/100ps
module slow_osc
(
   input  wire logic       i_ref_clk,
   input  wire logic [7:0] i_half,
   output logic            o_osc
);
   logic [7:0] cnt_r = 8'h00;
   wire logic  last = (cnt_r == i_half - 8'h01);
   initial o_osc = 1'b0;
   // Level flips every i_half cycles, far slower than the timer clock
   always @(posedge i_ref_clk)
   begin
      cnt_r <= #1 last ? 8'h00 : cnt_r + 8'h01;
      if (last)
         o_osc <= #1 ~o_osc;
   end
endmodule

/* verilog/edge_divider.sv */
// Rising edge detector with optional divide-by-N pulse output
`timescale 1ns/100ps
module edge_divider
#(
   parameter logic [3:0] LAST = 4'h7
)
(
   input  wire logic i_ref_clk,
   input  wire logic i_srst,
   input  wire logic i_level,
   input  wire logic i_divide,
   output logic      o_pulse
);

   logic       prev_r;
   logic [3:0] cnt_r;
   logic [3:0] cnt_nxt;
   wire        rise = i_level & ~prev_r;
   wire        wrap = (cnt_r == LAST);

   // Count rising edges, pulse on the wrap when dividing
   assign cnt_nxt = rise ? (wrap ? osc_capture_pkg::DIV_CNT_RESET
                                 : cnt_r + osc_capture_pkg::DIV_ONE)
                         : cnt_r;
   assign o_pulse = rise & (~i_divide | wrap);

   // Input sampled synchronously, so one flop is enough for the edge
   always_ff @(posedge i_ref_clk)
   begin
      if (i_srst)
      begin
         prev_r <= 1'b0;
         cnt_r  <= osc_capture_pkg::DIV_CNT_RESET;
      end
      else
      begin
         prev_r <= i_level;
         cnt_r  <= cnt_nxt;
      end
   end

endmodule

/* verilog/osc_capture_pkg.sv */
// Shared constants and carrier types for the oscillator period capture timer
package osc_capture_pkg;

   localparam int unsigned CNT_W          = 16;
   localparam int unsigned BYTE_W         = 8;
   localparam int unsigned EXT_DIV        = 8;   // External clock divide
   localparam int unsigned SYS_DIV        = 12;  // System clock prescale
   localparam logic [15:0] CNT_RESET      = 16'h0000;
   localparam logic [15:0] RELOAD_RESET   = 16'h0000;
   localparam logic [3:0]  DIV_CNT_RESET  = 4'h0;
   localparam logic [15:0] CNT_ONE        = 16'h0001;
   localparam logic [3:0]  DIV_ONE        = 4'h1;
   localparam logic [3:0]  SYS_DIV_LAST   = 4'hb;
   localparam logic [3:0]  EXT_DIV_LAST   = 4'h7;
   localparam logic [15:0] FULL_SCALE     = 16'hffff;

   // Counting clock choices
   typedef enum logic [1:0]
   {
      SRC_SYSTEM_CLOCK_DIV12 = 2'h0,
      SRC_EXT_DIV8           = 2'h1,
      SRC_COMPARATOR         = 2'h2,
      SRC_SYSTEM_CLOCK       = 2'h3
   } count_src_t;

   // Control bits from the register file
   typedef struct packed
   {
      logic       osc_capture_enable;
      logic       split_mode_select;
      logic       capture_source_select;
      logic       low_byte_system_clock_select;
      logic [1:0] clock_select;
      logic       run;
   } ctrl_t;

   // Captured value and flag
   typedef struct packed
   {
      logic [7:0] reload_high_byte;
      logic [7:0] reload_low_byte;
      logic       high_overflow_flag;
   } status_t;

endpackage

/* verilog/osc_period_capture.sv */
// Timer with oscillator period capture into the reload register pair
// How it works
// RULE_01: Capture happens only while osc_capture_enable is 1.
// RULE_02: Software keeps split_mode_select at 0 in capture mode.
// RULE_03: Capture on each RTC rising edge, or every 8 external cycles.
// RULE_04: Capture copies counter high and low bytes into reload bytes.
// RULE_05: Capture sets high_overflow_flag; interrupt request when enabled.
// RULE_06: System clock count, RTC source, enabled: capture on each RTC rise.
// RULE_07: Counting clock should be much faster than the capture clock.
// RULE_08: Count system clock, system clock/12, external/8 or comparator.
// RULE_09: Capture never resets or stops the counter.
`timescale 1ns/100ps
module osc_period_capture
(
   input  wire logic                   i_ref_clk,
   input  wire logic                   i_srst,
   input  wire osc_capture_pkg::ctrl_t i_ctrl,
   input  wire logic                   i_rtc_osc,
   input  wire logic                   i_ext_osc,
   input  wire logic                   i_comparator,
   input  wire logic                   i_flag_clear,
   input  wire logic                   i_irq_enable,
   output osc_capture_pkg::status_t    o_status,
   output logic [7:0]                  o_counter_high_byte,
   output logic [7:0]                  o_counter_low_byte,
   output logic                        o_capture,
   output logic                        o_irq
);

   ////////////////////////////////////////////////////////////////////////
   // Sizes and signals

   // Byte lanes of the count and of the captured pair
   localparam int unsigned BYTE_W    = osc_capture_pkg::BYTE_W;
   localparam int unsigned NUM_BYTES = osc_capture_pkg::CNT_W / BYTE_W;

   // Counter, captured pair and flag
   logic [15:0] count_r;
   logic [15:0] count_nxt;
   wire  [15:0] reload_word;
   logic        flag_r;
   logic        flag_nxt;

   // System clock prescaler
   logic [3:0]  pre_r;
   logic [3:0]  pre_nxt;
   logic        pre_wrap;

   // Edge pulses and counting ticks
   logic        rtc_pulse;
   logic        ext_pulse;
   logic        ext_tick;
   logic        cmp_tick;
   logic        tick;

   // Capture event of this cycle
   logic        capture_evt;

   // Counting source and its decode
   osc_capture_pkg::count_src_t src;
   logic        src_sys;
   logic        src_div12;
   logic        src_ext;
   logic        src_cmp;

   ////////////////////////////////////////////////////////////////////////
   // Edge sources

   // RTC edges pass undivided
   edge_divider #(.LAST(osc_capture_pkg::EXT_DIV_LAST)) u_rtc_edge
   (
      .i_ref_clk (i_ref_clk),
      .i_srst    (i_srst),
      .i_level   (i_rtc_osc),
      .i_divide  (1'b0),
      .o_pulse   (rtc_pulse)
   );

   // External oscillator divided by eight, shared by count and capture
   edge_divider #(.LAST(osc_capture_pkg::EXT_DIV_LAST)) u_ext_div
   (
      .i_ref_clk (i_ref_clk),
      .i_srst    (i_srst),
      .i_level   (i_ext_osc),
      .i_divide  (1'b1),
      .o_pulse   (ext_pulse)
   );

   // Comparator rising edges as counting ticks
   edge_divider #(.LAST(osc_capture_pkg::EXT_DIV_LAST)) u_cmp_edge
   (
      .i_ref_clk (i_ref_clk),
      .i_srst    (i_srst),
      .i_level   (i_comparator),
      .i_divide  (1'b0),
      .o_pulse   (cmp_tick)
   );

   // One divider feeds count and capture, so both see the same phase
   assign ext_tick = ext_pulse;

   ////////////////////////////////////////////////////////////////////////
   // Counting clock selection

   // Low byte system clock select overrides the scaled choice
   assign src = i_ctrl.low_byte_system_clock_select
                ? osc_capture_pkg::SRC_SYSTEM_CLOCK
                : osc_capture_pkg::count_src_t'(i_ctrl.clock_select);

   // One-hot decode of the counting source
   assign src_sys   = (src == osc_capture_pkg::SRC_SYSTEM_CLOCK);
   assign src_div12 = (src == osc_capture_pkg::SRC_SYSTEM_CLOCK_DIV12);
   assign src_ext   = (src == osc_capture_pkg::SRC_EXT_DIV8);
   assign src_cmp   = (src == osc_capture_pkg::SRC_COMPARATOR);

   // Pick the counting tick; see RULE_08, see RULE_06
   assign tick = src_sys
               | (src_div12 & pre_wrap)
               | (src_ext & ext_tick)
               | (src_cmp & cmp_tick);

   ////////////////////////////////////////////////////////////////////////
   // Prescaler

   // Divide by twelve; wraps after its last count
   assign pre_wrap = (pre_r == osc_capture_pkg::SYS_DIV_LAST);
   assign pre_nxt  = pre_wrap ? osc_capture_pkg::DIV_CNT_RESET
                              : pre_r + osc_capture_pkg::DIV_ONE;

   // Free running; a fresh divide-by-12 choice may tick early once
   always_ff @(posedge i_ref_clk)
   begin
      if (i_srst)
         pre_r <= osc_capture_pkg::DIV_CNT_RESET;
      else
         pre_r <= pre_nxt;
   end

   ////////////////////////////////////////////////////////////////////////
   // Capture event

   // Event source chosen by select bit, gated by enable
   assign capture_evt = i_ctrl.osc_capture_enable &            // see RULE_01
                        (i_ctrl.capture_source_select
                         ? ext_pulse : rtc_pulse);             // see RULE_03

   ////////////////////////////////////////////////////////////////////////
   // Running counter

   // Counter keeps running through a capture; see RULE_09
   assign count_nxt = (i_ctrl.run & tick) ? count_r + osc_capture_pkg::CNT_ONE
                                          : count_r;

   // Never cleared by a capture, so successive captures differ exactly
   always_ff @(posedge i_ref_clk)
   begin
      if (i_srst)
         count_r <= osc_capture_pkg::CNT_RESET;
      else
         count_r <= count_nxt;
   end

   ////////////////////////////////////////////////////////////////////////
   // Captured count, one register per byte

   // Both bytes load on the same edge, so the pair is never torn
   for (genvar g = 0; g < NUM_BYTES; g++)
   begin : g_reload
      logic [BYTE_W-1:0] byte_r;
      logic [BYTE_W-1:0] byte_nxt;

      // Copy value seen before this edge's increment; see RULE_04
      assign byte_nxt = capture_evt ? count_r[g * BYTE_W +: BYTE_W]
                                    : byte_r;

      // One byte of the pair, held until the next capture
      always_ff @(posedge i_ref_clk)
      begin
         if (i_srst)
            byte_r <= osc_capture_pkg::RELOAD_RESET[g * BYTE_W +: BYTE_W];
         else
            byte_r <= byte_nxt;
      end

      // Join the bytes back into one word for the outputs
      assign reload_word[g * BYTE_W +: BYTE_W] = byte_r;
   end

   ////////////////////////////////////////////////////////////////////////
   // Capture flag

   // Set wins over a clear in the same cycle; see RULE_05
   assign flag_nxt = capture_evt | (flag_r & ~i_flag_clear);

   // Held until cleared, so software cannot miss a capture
   always_ff @(posedge i_ref_clk)
   begin
      if (i_srst)
         flag_r <= 1'b0;
      else
         flag_r <= flag_nxt;
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs

   // Split mode is ignored here; software keeps it low, see RULE_02
   assign o_status.reload_high_byte   = reload_word[BYTE_W +: BYTE_W];
   assign o_status.reload_low_byte    = reload_word[0 +: BYTE_W];
   assign o_status.high_overflow_flag = flag_r;

   // Running count, visible byte by byte
   assign o_counter_high_byte         = count_r[BYTE_W +: BYTE_W];
   assign o_counter_low_byte          = count_r[0 +: BYTE_W];

   // Capture pulse is combinational, one cycle wide
   assign o_capture                   = capture_evt;

   ////////////////////////////////////////////////////////////////////////
   // Interrupt

   // Interrupt request follows the flag while enabled; see RULE_05
   assign o_irq                       = flag_r & i_irq_enable;

endmodule
